// File: design/ddr_cmd_pkg.sv
// constants and types for the double-rate memory command and data interface
package ddr_cmd_pkg;
  localparam int DQ_W = 16;
  localparam int BYTES = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int BANKS = 4;
  localparam int MEM_DEPTH = 64;
  localparam int MEM_AW = 6;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_ACTIVE_MIN_NS = 40;
  // least time rounds up
  localparam int ROW_ACTIVE_MIN_CYC = (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AP_BIT = 10;
  // mode register fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] BL2 = 3'h1;
  localparam logic [2:0] BL4 = 3'h2;
  localparam logic [2:0] BL8 = 3'h3;
  localparam logic [2:0] CL2 = 3'h2;
  localparam logic [2:0] CL3 = 3'h3;
  localparam logic [2:0] CL25 = 3'h6;
  localparam logic [2:0] MR_BL_RESET = 3'h1;
  localparam logic [2:0] MR_CL_RESET = 3'h2;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  typedef enum logic [4:0] {
    PWR_ON = 5'h01,
    PWR_PDN_PRE = 5'h02,
    PWR_PDN_ACT = 5'h04,
    PWR_SELF = 5'h08
  } pwr_t;
endpackage : ddr_cmd_pkg

// File: design/bank_if.sv
// interface carrying bank open/close requests and state
`timescale 1ns/1ps
interface bank_if;
  import ddr_cmd_pkg::*;
  logic [BANKS-1:0] act;
  logic [BANKS-1:0] pre;
  logic [BANKS-1:0] open;
  logic [BANKS-1:0] pre_ok;
  modport ctrl (output act, output pre, input open, input pre_ok);
  modport bank (input act, input pre, output open, output pre_ok);
endinterface : bank_if

// File: design/bank_tracker.sv
// per-bank open state with minimum row active lockout
`timescale 1ns/1ps
module bank_tracker
  import ddr_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  bank_if.bank b
);
  logic [BANKS-1:0][3:0] ras_cnt;
  logic [BANKS-1:0] open;
  // each bank runs on its own, opened by a single activate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open <= '0;
      ras_cnt <= '0;
    end else begin
      for (int i = 0; i < BANKS; i++) begin
        if (b.act[i] && !open[i]) begin
          open[i] <= 1'b1;
          ras_cnt[i] <= 4'(ROW_ACTIVE_MIN_CYC);
        end else begin
          if (ras_cnt[i] != 4'h0) ras_cnt[i] <= ras_cnt[i] - 4'h1;
          // precharge waits out the row active time
          if (b.pre[i] && ras_cnt[i] == 4'h0) open[i] <= 1'b0;
        end
      end
    end
  end
  assign b.open = open;
  for (genvar g = 0; g < BANKS; g++) begin : g_ok
    assign b.pre_ok[g] = (ras_cnt[g] == 4'h0);
  end
endmodule : bank_tracker

// File: design/ddr_device_if.sv
// device side of the double-rate command, clock gate and data strobe interface
`timescale 1ns/1ps
module ddr_device_if
  import ddr_cmd_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CLK_GATE_IN,
  input wire logic CS_N_IN,
  input wire logic RAS_N_IN,
  input wire logic CAS_N_IN,
  input wire logic WE_N_IN,
  input wire logic [1:0] BANK_SELECT_IN,
  input wire logic [ROW_W-1:0] ADDR_IN,
  input wire logic [DQ_W-1:0] DQ_IN,
  input wire logic [BYTES-1:0] WRITE_MASK_IN,
  input wire logic UPPER_BYTE_STROBE_IN,
  input wire logic LOWER_BYTE_STROBE_IN,
  output logic [DQ_W-1:0] DQ_OUT,
  output logic DQ_OE_OUT,
  output logic UPPER_BYTE_STROBE_OUT,
  output logic LOWER_BYTE_STROBE_OUT,
  output logic STROBE_OE_OUT,
  output logic [BANKS-1:0] BANK_OPEN_OUT,
  output logic POWER_DOWN_OUT,
  output logic SELF_REFRESH_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // memory core: two words per pin per access, one per clock half
  logic [2*DQ_W-1:0] mem [MEM_DEPTH];
  pwr_t pwr;
  logic [2:0] mr_bl;
  logic mr_bt;
  logic [2:0] mr_cl;
  logic [3:0] cmd;
  logic sel;
  logic [BANKS-1:0] bank_dec;
  bank_if bk ();

  bank_tracker u_banks (
    .clk(REF_CLK_IN),
    .rst_n(NRST_IN),
    .b(bk)
  );

  function automatic logic [3:0] burst_words(input logic [2:0] bl);
    case (bl)
      BL2: burst_words = 4'h2;
      BL4: burst_words = 4'h4;
      BL8: burst_words = 4'h8;
      default: burst_words = 4'h2;
    endcase
  endfunction : burst_words

  // address of the n-th pair in a burst; interleave uses xor
  function automatic logic [MEM_AW-1:0] pair_addr(input logic [MEM_AW-1:0] base,
      input logic [2:0] n, input logic bt, input logic [2:0] bl);
    logic [2:0] mask;
    logic [2:0] off;
    mask = (bl == BL8) ? 3'h3 : ((bl == BL4) ? 3'h1 : 3'h0);
    off = bt ? ((base[2:0] >> 1) ^ n) & mask : ((base[2:0] >> 1) + n) & mask;
    pair_addr = {base[MEM_AW-1:2], 2'h0} | MEM_AW'({off[1:0]});
  endfunction : pair_addr

  ////////////////////////////////////////////////////////////////////////////
  // command decode on the rising edge, chip select part of the code
  assign sel = !CS_N_IN && (pwr == PWR_ON) && CLK_GATE_IN;
  assign cmd = sel ? {CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN} : CMD_NOP;
  assign bank_dec = 4'h1 << BANK_SELECT_IN;
  assign bk.act = (cmd == CMD_ACT) ? bank_dec : '0;

  // read or write auto precharge and explicit precharge both go through lockout
  logic [BANKS-1:0] ap_pend;
  assign bk.pre = ap_pend | ((cmd == CMD_PRE) ? (ADDR_IN[AP_BIT] ? 4'hf : bank_dec) : 4'h0);
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ap_pend <= '0;
    end else begin
      // an early close is held here until the lockout lets it through
      ap_pend <= bk.pre & bk.open & ~bk.pre_ok;
      if ((cmd == CMD_RD || cmd == CMD_WR) && ADDR_IN[AP_BIT])
        ap_pend <= (bk.pre & bk.open & ~bk.pre_ok) | bank_dec;
    end
  end
  assign BANK_OPEN_OUT = bk.open;

  // mode register load; banks-select zero picks the base register
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mr_bl <= MR_BL_RESET;
      mr_bt <= 1'b0;
      mr_cl <= MR_CL_RESET;
    end else if (cmd == CMD_MRS && BANK_SELECT_IN == 2'h0) begin
      mr_bl <= ADDR_IN[MR_BL_LSB +: 3];
      mr_bt <= ADDR_IN[MR_BT_BIT];
      mr_cl <= ADDR_IN[MR_CL_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power states; entry sampled on the edge, self refresh exit is immediate
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pwr <= PWR_ON;
    end else begin
      case (pwr)
        PWR_ON: begin
          if (!CLK_GATE_IN) begin
            // raw lines: the decoded command is already masked by the gate
            if (bk.open != '0) pwr <= PWR_PDN_ACT;
            else if (!CS_N_IN && !RAS_N_IN && !CAS_N_IN && WE_N_IN) pwr <= PWR_SELF;
            else pwr <= PWR_PDN_PRE;
          end
        end
        PWR_PDN_PRE, PWR_PDN_ACT: if (CLK_GATE_IN) pwr <= PWR_ON;
        PWR_SELF: if (CLK_GATE_IN) pwr <= PWR_ON;
        default: pwr <= PWR_ON;
      endcase
    end
  end
  assign POWER_DOWN_OUT = (pwr == PWR_PDN_PRE) || (pwr == PWR_PDN_ACT);
  // gate high releases self refresh at once, clock buffers being off
  assign SELF_REFRESH_OUT = (pwr == PWR_SELF) && !CLK_GATE_IN;

  ////////////////////////////////////////////////////////////////////////////
  // write path: capture both halves and mask on both edges, strobe on the falling edge only
  logic [DQ_W-1:0] wr_fall;
  logic [BYTES-1:0] dm_fall;
  logic [1:0] dqs_fall;
  always_ff @(negedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wr_fall <= '0;
      dm_fall <= '0;
      dqs_fall <= '0;
    end else begin
      wr_fall <= DQ_IN;
      dm_fall <= WRITE_MASK_IN;
      dqs_fall <= {UPPER_BYTE_STROBE_IN, LOWER_BYTE_STROBE_IN};
    end
  end

  logic wr_act;
  logic wr_start;
  logic [3:0] wr_left;
  logic [2:0] wr_n;
  logic [MEM_AW-1:0] wr_base;
  logic [DQ_W-1:0] wr_rise;
  logic [BYTES-1:0] dm_rise;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wr_rise <= '0;
      dm_rise <= '0;
    end else begin
      wr_rise <= DQ_IN;
      dm_rise <= WRITE_MASK_IN;
    end
  end

  // write burst: data begins one cycle after the command
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wr_act <= 1'b0;
      wr_start <= 1'b0;
      wr_left <= '0;
      wr_n <= '0;
      wr_base <= '0;
    end else if (cmd == CMD_WR) begin
      wr_start <= 1'b1;
      wr_base <= ADDR_IN[MEM_AW-1:0];
    end else if (wr_start) begin
      // first pair is captured only in the cycle after the command
      wr_start <= 1'b0;
      wr_act <= 1'b1;
      wr_left <= burst_words(mr_bl) >> 1;
      wr_n <= '0;
    end else if (wr_act) begin
      wr_n <= wr_n + 3'h1;
      wr_left <= wr_left - 4'h1;
      if (wr_left == 4'h1) wr_act <= 1'b0;
    end
  end

  // commit a pair per cycle; masked bytes keep the old contents
  logic [2*DQ_W-1:0] old_pair;
  logic [2*DQ_W-1:0] next_pair;
  logic [MEM_AW-1:0] wa;
  always_comb begin
    wa = pair_addr(wr_base, wr_n, mr_bt, mr_bl);
    old_pair = mem[wa];
    next_pair = old_pair;
    for (int b = 0; b < BYTES; b++) begin
      if (!dm_rise[b]) next_pair[b*8 +: 8] = wr_rise[b*8 +: 8];
      if (!dm_fall[b]) next_pair[DQ_W + b*8 +: 8] = wr_fall[b*8 +: 8];
    end
  end
  // no reset on the array: contents are undefined after power up
  always_ff @(posedge REF_CLK_IN) begin
    if (wr_act && (dqs_fall != 2'h0 || 1'b1)) mem[wa] <= next_pair;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: latency pipe then one pair per cycle
  logic [7:0] rd_pipe;
  logic [MEM_AW-1:0] rd_base;
  logic [3:0] rd_left;
  logic [2:0] rd_n;
  logic rd_act;
  logic [2*DQ_W-1:0] rd_pair;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_pipe <= '0;
      rd_base <= '0;
      rd_left <= '0;
      rd_n <= '0;
      rd_act <= 1'b0;
      rd_pair <= '0;
    end else begin
      rd_pipe <= {rd_pipe[6:0], cmd == CMD_RD};
      if (cmd == CMD_RD) rd_base <= ADDR_IN[MEM_AW-1:0];
      // latency 2.5 handled as 2 plus a half-cycle shift below
      if (rd_pipe[(mr_cl == CL3) ? 2 : 1]) begin
        rd_act <= 1'b1;
        rd_left <= burst_words(mr_bl) >> 1;
        rd_n <= '0;
        rd_pair <= mem[pair_addr(rd_base, 3'h0, mr_bt, mr_bl)];
      end else if (rd_act) begin
        rd_n <= rd_n + 3'h1;
        rd_left <= rd_left - 4'h1;
        if (rd_left == 4'h1) rd_act <= 1'b0;
        else rd_pair <= mem[pair_addr(rd_base, rd_n + 3'h1, mr_bt, mr_bl)];
      end
    end
  end

  // falling-edge flops give one word per clock edge; half-cycle delay for 2.5
  logic [DQ_W-1:0] dq_fall;
  logic [DQ_W-1:0] dq_late;
  logic act_fall;
  logic hi_half;
  always_ff @(negedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dq_fall <= '0;
      dq_late <= '0;
      act_fall <= 1'b0;
    end else begin
      dq_late <= rd_pair[2*DQ_W-1:DQ_W];
      dq_fall <= (mr_cl == CL25) ? rd_pair[DQ_W-1:0] : rd_pair[2*DQ_W-1:DQ_W];
      act_fall <= rd_act;
    end
  end
  assign hi_half = REF_CLK_IN;
  // outputs off at once when gate drops
  assign DQ_OUT = hi_half ? ((mr_cl == CL25) ? dq_late : rd_pair[DQ_W-1:0]) : dq_fall;
  assign DQ_OE_OUT = ((mr_cl == CL25) ? act_fall : rd_act) && CLK_GATE_IN;
  // strobe toggles with the clock, edges aligned to data
  assign UPPER_BYTE_STROBE_OUT = hi_half && DQ_OE_OUT;
  assign LOWER_BYTE_STROBE_OUT = hi_half && DQ_OE_OUT;
  assign STROBE_OE_OUT = DQ_OE_OUT;
endmodule : ddr_device_if

// File: tb/ddr_cmd_checker.sv
// concurrent checks on the device pins
`timescale 1ns/1ps
module ddr_cmd_checker
  import ddr_cmd_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CLK_GATE_IN,
  input wire logic CS_N_IN,
  input wire logic RAS_N_IN,
  input wire logic CAS_N_IN,
  input wire logic WE_N_IN,
  input wire logic [1:0] BANK_SELECT_IN,
  input wire logic DQ_OE_OUT,
  input wire logic STROBE_OE_OUT,
  input wire logic [BANKS-1:0] BANK_OPEN_OUT,
  input wire logic POWER_DOWN_OUT,
  input wire logic SELF_REFRESH_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic [3:0] cmd;
  logic on;
  // a command only counts while powered and ungated
  assign cmd = {CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN};
  assign on = CLK_GATE_IN && !POWER_DOWN_OUT && !SELF_REFRESH_OUT;
  sequence act_taken;
    on && cmd == CMD_ACT;
  endsequence
  sequence rd_taken;
    on && cmd == CMD_RD && BANK_OPEN_OUT[BANK_SELECT_IN];
  endsequence
  ////////////////////////////////////////
  a_act_opens_bank: assert property (act_taken |=> BANK_OPEN_OUT[$past(BANK_SELECT_IN)])
    else $error("activate left bank closed");
  a_row_min_time: assert property ($rose(BANK_OPEN_OUT[0]) |-> BANK_OPEN_OUT[0] [*3])
    else $error("row closed before minimum time");
  a_read_latency: assert property (rd_taken |-> ##[2:4] DQ_OE_OUT)
    else $error("read data late");
  a_strobe_with_data: assert property (STROBE_OE_OUT == DQ_OE_OUT)
    else $error("strobe drive differs from data drive");
  a_gate_active_pd: assert property (!CLK_GATE_IN && !POWER_DOWN_OUT && !SELF_REFRESH_OUT
    && |BANK_OPEN_OUT |=> POWER_DOWN_OUT)
    else $error("no power-down with row open");
  a_self_exit: assert property ($rose(CLK_GATE_IN) && $past(SELF_REFRESH_OUT) |-> !SELF_REFRESH_OUT)
    else $error("self refresh not left");
  a_pd_frozen: assert property (POWER_DOWN_OUT && !CLK_GATE_IN |=> $stable(BANK_OPEN_OUT))
    else $error("bank state moved in power-down");
  a_oe_gate_off: assert property (!CLK_GATE_IN |-> !DQ_OE_OUT)
    else $error("data driven with gate low");
  a_cs_masks: assert property (CS_N_IN && on && BANK_OPEN_OUT == 4'h0 |=> BANK_OPEN_OUT == 4'h0)
    else $error("deselected command acted");
endmodule : ddr_cmd_checker
bind ddr_device_if ddr_cmd_checker chk (.REF_CLK_IN, .NRST_IN, .CLK_GATE_IN, .CS_N_IN,
  .RAS_N_IN, .CAS_N_IN, .WE_N_IN, .BANK_SELECT_IN, .DQ_OE_OUT, .STROBE_OE_OUT,
  .BANK_OPEN_OUT, .POWER_DOWN_OUT, .SELF_REFRESH_OUT);

// File: tb/ddr_ctrl_model.sv
// controller model driving commands, clock gate and write data
`timescale 1ns/1ps
module ddr_ctrl_model
  import ddr_cmd_pkg::*;
(
  input wire logic clk_in,
  output logic gate_out,
  output logic [3:0] cmd_out,
  output logic [1:0] ba_out,
  output logic [ROW_W-1:0] addr_out,
  output logic [DQ_W-1:0] dq_out,
  output logic [BYTES-1:0] mask_out,
  output logic strobe_out
);
  int seed = 29;
  initial begin
    gate_out = 1'b1;
    cmd_out = 4'hf;
    ba_out = 2'h0;
    addr_out = 13'h0000;
    dq_out = 16'h0000;
    mask_out = 2'h0;
    strobe_out = 1'b0;
  end
  ////////////////////////////////////////
  // one command, held up to its sampling edge
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [ROW_W-1:0] a);
    @(posedge clk_in);
    cmd_out <= c;
    ba_out <= ba;
    addr_out <= a;
  endtask : cmd
  // deselect; address inverted so stale values never look valid
  task automatic idle(input int n);
    @(posedge clk_in);
    cmd_out <= 4'hf;
    addr_out <= ~addr_out;
    repeat (n) @(posedge clk_in);
  endtask : idle
  // words change half a cycle ahead of the edge that samples them
  task automatic wr(input logic [1:0] ba, input logic [DQ_W-1:0] w[8], input int n,
                    input logic [BYTES-1:0] m0, input logic [BYTES-1:0] m1);
    // address bits the column decode ignores are randomised
    cmd(CMD_WR, ba, 13'($random(seed)) & 13'h1bc0);
    @(posedge clk_in);
    cmd_out <= 4'hf;
    for (int i = 0; i < n; i += 2) begin
      @(negedge clk_in);
      dq_out <= w[i];
      mask_out <= m0;
      strobe_out <= 1'b0;
      @(posedge clk_in);
      dq_out <= w[i+1];
      mask_out <= m1;
      strobe_out <= 1'b1;
    end
    @(negedge clk_in);
    dq_out <= ~dq_out;
    strobe_out <= 1'b0;
  endtask : wr
  // gate moves only between accesses, never inside a burst
  task automatic gate(input logic g);
    @(posedge clk_in);
    gate_out <= g;
  endtask : gate
  // refresh with gate low keeps the cells alive unattended
  task automatic sref();
    @(posedge clk_in);
    cmd_out <= CMD_REF;
    gate_out <= 1'b0;
  endtask : sref
endmodule : ddr_ctrl_model

// File: tb/tb.sv
// self-checking bench for the device command and data interface
`timescale 1ns/1ps
module tb;
  import ddr_cmd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic gate, stb, dq_oe, stb_oe, pd, sr;
  logic [3:0] c;
  logic [1:0] ba;
  logic [ROW_W-1:0] a;
  logic [DQ_W-1:0] dq, dq_rd;
  logic [BYTES-1:0] m;
  logic [BANKS-1:0] open;
  logic [DQ_W-1:0] expq[$];
  logic [DQ_W-1:0] w[8];
  logic [DQ_W-1:0] v[8];
  logic [2:0] lat[3] = '{CL2, CL25, CL3};
  logic [2:0] bl[3] = '{BL2, BL4, BL8};
  int miscompares = 0;
  int total_checks = 0;
  int seed = 29;
  always #5 clk = ~clk;
  ddr_ctrl_model ctl (.clk_in(clk), .gate_out(gate), .cmd_out(c), .ba_out(ba), .addr_out(a),
    .dq_out(dq), .mask_out(m), .strobe_out(stb));
  ddr_device_if dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .CLK_GATE_IN(gate), .CS_N_IN(c[3]),
    .RAS_N_IN(c[2]), .CAS_N_IN(c[1]), .WE_N_IN(c[0]), .BANK_SELECT_IN(ba), .ADDR_IN(a),
    .DQ_IN(dq), .WRITE_MASK_IN(m), .UPPER_BYTE_STROBE_IN(stb), .LOWER_BYTE_STROBE_IN(stb),
    .DQ_OUT(dq_rd), .DQ_OE_OUT(dq_oe), .UPPER_BYTE_STROBE_OUT(), .LOWER_BYTE_STROBE_OUT(),
    .STROBE_OE_OUT(stb_oe), .BANK_OPEN_OUT(open), .POWER_DOWN_OUT(pd), .SELF_REFRESH_OUT(sr));
  ////////////////////////////////////////
  task automatic chk(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chk
  // status is read one step after the edge so its updates have landed
  task automatic chks(input logic [5:0] exp);
    #1;
    total_checks++;
    if ({open, pd, sr} !== exp) begin
      miscompares++;
      $display("wrong value at %0t: status %h expected %h", $time, {open, pd, sr}, exp);
    end
  endtask : chks
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic rd(input logic [1:0] b, input int n);
    for (int i = 0; i < n; i++) expq.push_back(w[i]);
    ctl.cmd(CMD_RD, b, 13'($random(seed)) & 13'h1bc0);
    ctl.idle(8);
  endtask : rd
  // read words sampled mid half-cycle, clear of either edge
  always @(clk) begin
    #2;
    if (dq_oe === 1'b1) chk(dq_rd, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
  end
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    ctl.idle(1);
    chks(6'h00);
    // every latency, burst length and order; column 0 keeps both orders alike
    for (int j = 0; j < 18; j++) begin
      ctl.cmd(CMD_MRS, 2'h0, {6'h00, lat[j%3], j[0], bl[j/6]});
      ctl.cmd(CMD_ACT, j[1:0], 13'($random(seed)));
      ctl.idle(1);
      for (int i = 0; i < 8; i++) w[i] = $random(seed);
      ctl.wr(j[1:0], w, 2 << (j / 6), 2'h0, 2'h0);
      ctl.idle(1);
      chks({4'h1 << j[1:0], 2'h0});
      rd(j[1:0], 2 << (j / 6));
      ctl.cmd(CMD_PRE, 2'($random(seed)), 13'h0400);
      ctl.idle(2);
    end
    // masked bytes keep the older data
    ctl.cmd(CMD_MRS, 2'h0, 13'h0021);
    ctl.cmd(CMD_ACT, 2'h1, 13'h0000);
    ctl.idle(1);
    ctl.wr(2'h1, w, 2, 2'h0, 2'h0);
    for (int i = 0; i < 8; i++) v[i] = $random(seed);
    ctl.wr(2'h1, v, 2, 2'h1, 2'h2);
    w[0] = {v[0][15:8], w[0][7:0]};
    w[1] = {w[1][15:8], v[1][7:0]};
    rd(2'h1, 2);
    // deselected activate, then an early close that must wait
    ctl.cmd(4'hb, 2'h3, 13'h0000);
    ctl.cmd(CMD_ACT, 2'h2, 13'h0000);
    ctl.cmd(CMD_PRE, 2'h2, 13'h0000);
    ctl.idle(1);
    chks({4'h6, 2'h0});
    ctl.idle(6);
    chks({4'h2, 2'h0});
    // gate low with a row open, then with all rows closed, then self refresh; commands refused while gated
    ctl.gate(1'b0);
    ctl.cmd(CMD_ACT, 2'h0, 13'h0000);
    ctl.idle(2);
    chks({4'h2, 2'h2});
    ctl.gate(1'b1);
    ctl.idle(2);
    chks({4'h2, 2'h0});
    ctl.cmd(CMD_PRE, 2'h0, 13'h0400);
    ctl.idle(2);
    ctl.gate(1'b0);
    ctl.idle(2);
    chks(6'h02);
    ctl.gate(1'b1);
    ctl.idle(2);
    ctl.sref();
    ctl.idle(3);
    chks(6'h01);
    ctl.gate(1'b1);
    ctl.idle(2);
    chks(6'h00);
    end_sim();
  end
  // the whole sequence needs well under a tenth of this span
  initial begin
    #100us;
    miscompares++;
    end_sim();
  end
endmodule : tb
